/* File: rtl/stc_top.sv */
// Top of the tuning control bit block: register port, staging, commit and checks
`timescale 1ns/100ps
module stc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_enable,
  input wire logic [stc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [stc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [stc_pkg::DATA_W-1:0] reg_rdata,
  output logic [1:0] pump_current_level,
  output logic [11:0] pump_current_ua,
  output logic osc_buffer_disable,
  output logic ref_buffer_out_en,
  output logic am_mode,
  output logic dac_in_ref_sel,
  output logic [7:0] align_dac_a_gain,
  output logic [5:0] align_dac_a_offset,
  output logic signed [6:0] align_dac_a_offs_step,
  output logic [7:0] align_dac_b_gain,
  output logic [5:0] align_dac_b_offset,
  output logic signed [6:0] align_dac_b_offs_step
);
  import stc_pkg::*;

  typedef struct packed {
    logic [IMG_W-1:0] stage;
    logic [IMG_W-1:0] active;
    logic pending;
    logic [DATA_W-1:0] rdata;
  } stc_core_t;

  stc_core_t core_reg;
  stc_core_t core_next;
  logic commit;
  logic wr_hit;
  stc_fields_if fields();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True for the three image words that software may write
  function automatic logic stc_is_image(input logic [ADDR_W-1:0] addr);
    stc_is_image = (addr == ADDR_WORD0) || (addr == ADDR_WORD1) || (addr == ADDR_WORD2);
  endfunction : stc_is_image

  // Merge masked write data into an old word
  function automatic logic [31:0] stc_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [31:0] mask);
    stc_merge = (old_w & ~mask) | (new_w & mask);
  endfunction : stc_merge

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  // Commit pulse follows the falling enable by one cycle
  stc_frame_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .bus_enable(bus_enable),
    .commit(commit)
  );

  stc_field_decode u_dec (
    .clk(clk),
    .rst_n(rst_n),
    .fields(fields.dst),
    .pump_current_level(pump_current_level),
    .pump_current_ua(pump_current_ua),
    .osc_buffer_disable(osc_buffer_disable),
    .ref_buffer_out_en(ref_buffer_out_en),
    .am_mode(am_mode),
    .dac_in_ref_sel(dac_in_ref_sel),
    .align_dac_a_gain(align_dac_a_gain),
    .align_dac_a_offset(align_dac_a_offset),
    .align_dac_a_offs_step(align_dac_a_offs_step),
    .align_dac_b_gain(align_dac_b_gain),
    .align_dac_b_offset(align_dac_b_offset),
    .align_dac_b_offs_step(align_dac_b_offs_step)
  );

  // ----------------------------------------------------------------
  // Field extraction from the committed image
  // ----------------------------------------------------------------
  // Decoder only ever sees the active copy, so staging writes stay hidden
  assign fields.pump_level = core_reg.active[POS_PUMP +: PUMP_W];
  assign fields.osc_dis = core_reg.active[POS_OSC_DIS];
  assign fields.am_mode = core_reg.active[POS_MODE];
  assign fields.gain_a = core_reg.active[POS_GAIN_A +: GAIN_W];
  assign fields.offs_a = core_reg.active[POS_OFFS_A +: OFFS_W];
  assign fields.gain_b = core_reg.active[POS_GAIN_B +: GAIN_W];
  assign fields.offs_b = core_reg.active[POS_OFFS_B +: OFFS_W];

  assign wr_hit = reg_wr && stc_is_image(reg_addr);

  // ----------------------------------------------------------------
  // Register core
  // ----------------------------------------------------------------
  // A write in the commit cycle lands in staging and keeps pending set
  always_comb begin
    core_next = core_reg;
    core_next.rdata = '0;
    if (commit) begin
      core_next.active = core_reg.stage;
      core_next.pending = 1'b0;
    end
    if (wr_hit) begin
      core_next.pending = 1'b1;
    end
    if (reg_wr) begin
      case (reg_addr)
        ADDR_WORD0: core_next.stage[31:0] = stc_merge(core_reg.stage[31:0], reg_wdata, MASK_WORD0);
        ADDR_WORD1: core_next.stage[63:32] = stc_merge(core_reg.stage[63:32], reg_wdata, MASK_WORD1);
        ADDR_WORD2: core_next.stage[71:64] = (core_reg.stage[71:64] & ~MASK_WORD2) | (reg_wdata[7:0] & MASK_WORD2);
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_WORD0: core_next.rdata = core_reg.stage[31:0];
        ADDR_WORD1: core_next.rdata = core_reg.stage[63:32];
        ADDR_WORD2: core_next.rdata = {24'h000000, core_reg.stage[71:64]};
        ADDR_STATUS: begin
          core_next.rdata[ST_PENDING] = core_reg.pending;
          core_next.rdata[ST_AM] = core_reg.active[POS_MODE];
          core_next.rdata[ST_PUMP +: PUMP_W] = core_reg.active[POS_PUMP +: PUMP_W];
          core_next.rdata[ST_OSC] = core_reg.active[POS_OSC_DIS];
        end
        default: core_next.rdata = '0; // Unmapped reads return zero
      endcase
    end
  end

  // Core register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_reg <= '{stage: STAGE_RST, active: STAGE_RST, pending: 1'b0, rdata: '0};
    end else begin
      core_reg <= core_next;
    end
  end

  assign reg_rdata = core_reg.rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] stage_gain_a;
  logic [7:0] stage_gain_b;
  logic [5:0] stage_offs_a;
  logic [5:0] stage_offs_b;
  assign stage_gain_a = core_reg.stage[POS_GAIN_A +: GAIN_W];
  assign stage_gain_b = core_reg.stage[POS_GAIN_B +: GAIN_W];
  assign stage_offs_a = core_reg.stage[POS_OFFS_A +: OFFS_W];
  assign stage_offs_b = core_reg.stage[POS_OFFS_B +: OFFS_W];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_PUMP_MAP: assert property (commit ##2 1'b1 |->
      pump_current_ua == stc_pump_ua($past(core_reg.stage[POS_PUMP +: PUMP_W], 2)))
    else $error("pump current does not follow committed code");
  AST_BUF_GATE: assert property (commit |-> ##2 (ref_buffer_out_en == !$past(core_reg.stage[POS_OSC_DIS], 2))
      && (osc_buffer_disable != ref_buffer_out_en))
    else $error("reference buffer enable wrong");
  AST_MODE_SEL: assert property (commit |-> ##2 am_mode == $past(core_reg.stage[POS_MODE], 2))
    else $error("dac mode does not follow bit 34");
  AST_AM_REF: assert property (dac_in_ref_sel == am_mode)
    else $error("am mode without fixed reference");
  AST_GAIN_A: assert property (commit |-> ##2 align_dac_a_gain == $past(stage_gain_a, 2))
    else $error("first dac gain wrong");
  AST_GAIN_B: assert property (commit |-> ##2 align_dac_b_gain == $past(stage_gain_b, 2))
    else $error("second dac gain wrong");
  AST_OFFS_A: assert property (commit |-> ##2 align_dac_a_offset == $past(stage_offs_a, 2))
    else $error("first dac offset wrong");
  AST_OFFS_B: assert property (commit |-> ##2 align_dac_b_offset == $past(stage_offs_b, 2))
    else $error("second dac offset wrong");
  AST_OFFS_STEP: assert property ($changed(align_dac_a_offset) |->
      (align_dac_a_offs_step == 7'(OFFS_MID - {1'b0, align_dac_a_offset})))
    else $error("offset step not mirrored around code 31");
  AST_GAIN_HOLD: assert property (!commit ##1 !commit |=> $stable(align_dac_a_gain) && $stable(am_mode))
    else $error("decoded field changed without a command end");
  AST_ACTIVE_HOLD: assert property (!commit |=> $stable(core_reg.active))
    else $error("active image changed without commit");

  COV_AM_COMMIT: cover property (commit ##2 am_mode);
  COV_WRITE_IN_FRAME: cover property (bus_enable && wr_hit ##[1:20] commit);
  COV_MAX_PUMP: cover property (pump_current_ua == PUMP_UA_2000);
  COV_WRITE_AT_COMMIT: cover property (commit && wr_hit);

endmodule : stc_top

/* File: rtl/stc_pkg.sv */
// Constants, types and helpers shared by the synthesizer tuning control bit block
// Overview of operation
// - Bits 71:70 pick pump current 25, 100, 500 or 2000 microamperes.
// - Bit 69 low turns the reference buffer output on, high turns it off.
// - Bit 34 selects alignment DAC mode: low is FM, high is AM.
// - In AM mode both DAC gain and offset inputs take the fixed 3 V reference.
// - First DAC gain code is bits 36 to 43, bit 36 least significant.
// - Second DAC gain code is bits 0 to 7, bit 0 least significant.
// - Gain code is 256 linear steps, 0 minimum, 255 maximum, monotonic rising.
// - First DAC offset code is bits 44 to 49, bit 44 least significant.
// - Second DAC offset code is bits 8 to 13, bit 8 least significant.
// - Offset code is 64 linear steps, 0 most positive, 63 most negative, 31 near zero.
package stc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IMG_W = 72;
  localparam logic [7:0] ADDR_WORD0 = 8'h00;
  localparam logic [7:0] ADDR_WORD1 = 8'h04;
  localparam logic [7:0] ADDR_WORD2 = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // Implemented control bits inside each image word
  localparam logic [31:0] MASK_WORD0 = 32'h00003FFF;
  localparam logic [31:0] MASK_WORD1 = 32'h0003FFF4;
  localparam logic [7:0] MASK_WORD2 = 8'hE0;
  localparam logic [71:0] STAGE_RST = 72'h000000000000000000;

  // ----------------------------------------------------------------
  // Field positions in the control bit image
  // ----------------------------------------------------------------
  localparam int POS_GAIN_B = 0;
  localparam int POS_OFFS_B = 8;
  localparam int POS_MODE = 34;
  localparam int POS_GAIN_A = 36;
  localparam int POS_OFFS_A = 44;
  localparam int POS_OSC_DIS = 69;
  localparam int POS_PUMP = 70;
  localparam int GAIN_W = 8;
  localparam int OFFS_W = 6;
  localparam int PUMP_W = 2;
  localparam logic [6:0] OFFS_MID = 7'h1F;

  // Status word layout
  localparam int ST_PENDING = 0;
  localparam int ST_AM = 1;
  localparam int ST_PUMP = 2;
  localparam int ST_OSC = 4;

  // Pump currents in microamperes
  localparam logic [11:0] PUMP_UA_25 = 12'h019;
  localparam logic [11:0] PUMP_UA_100 = 12'h064;
  localparam logic [11:0] PUMP_UA_500 = 12'h1F4;
  localparam logic [11:0] PUMP_UA_2000 = 12'h7D0;

  typedef enum logic {FRM_IDLE, FRM_ACTIVE} stc_frame_state_t;

  // Pump code to current in microamperes
  function automatic logic [11:0] stc_pump_ua(input logic [1:0] level);
    case (level)
      2'h0: stc_pump_ua = PUMP_UA_25;
      2'h1: stc_pump_ua = PUMP_UA_100;
      2'h2: stc_pump_ua = PUMP_UA_500;
      default: stc_pump_ua = PUMP_UA_2000;
    endcase
  endfunction : stc_pump_ua

endpackage : stc_pkg

/* File: rtl/stc_fields_if.sv */
// Committed control fields passed from the register core to the decoder
`timescale 1ns/100ps
interface stc_fields_if;
  logic [1:0] pump_level;
  logic osc_dis;
  logic am_mode;
  logic [7:0] gain_a;
  logic [5:0] offs_a;
  logic [7:0] gain_b;
  logic [5:0] offs_b;
  modport src(output pump_level, osc_dis, am_mode, gain_a, offs_a, gain_b, offs_b);
  modport dst(input pump_level, osc_dis, am_mode, gain_a, offs_a, gain_b, offs_b);
endinterface : stc_fields_if

/* File: rtl/stc_frame_sync.sv */
// Command framing tracker: pulses commit when the enable line falls
`timescale 1ns/100ps
module stc_frame_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_enable,
  output logic commit
);
  import stc_pkg::*;

  typedef struct packed {
    stc_frame_state_t state;
    logic commit;
  } stc_sync_t;

  stc_sync_t sync_reg;
  stc_sync_t sync_next;

  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  // End of command is the falling enable, never a mid-frame level
  always_comb begin
    sync_next = sync_reg;
    sync_next.commit = 1'b0;
    case (sync_reg.state)
      FRM_IDLE: begin
        if (bus_enable) begin
          sync_next.state = FRM_ACTIVE;
        end
      end
      FRM_ACTIVE: begin
        if (!bus_enable) begin
          sync_next.state = FRM_IDLE;
          sync_next.commit = 1'b1;
        end
      end
      default: begin
        sync_next.state = FRM_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= '{state: FRM_IDLE, commit: 1'b0};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign commit = sync_reg.commit;

endmodule : stc_frame_sync

/* File: rtl/stc_field_decode.sv */
// Turns committed fields into registered analog select and enable values
`timescale 1ns/100ps
module stc_field_decode (
  input wire logic clk,
  input wire logic rst_n,
  stc_fields_if.dst fields,
  output logic [1:0] pump_current_level,
  output logic [11:0] pump_current_ua,
  output logic osc_buffer_disable,
  output logic ref_buffer_out_en,
  output logic am_mode,
  output logic dac_in_ref_sel,
  output logic [7:0] align_dac_a_gain,
  output logic [5:0] align_dac_a_offset,
  output logic signed [6:0] align_dac_a_offs_step,
  output logic [7:0] align_dac_b_gain,
  output logic [5:0] align_dac_b_offset,
  output logic signed [6:0] align_dac_b_offs_step
);
  import stc_pkg::*;

  typedef struct packed {
    logic [1:0] pump_level;
    logic [11:0] pump_ua;
    logic osc_dis;
    logic buf_en;
    logic am;
    logic ref_sel;
    logic [7:0] gain_a;
    logic [5:0] offs_a;
    logic [6:0] step_a;
    logic [7:0] gain_b;
    logic [5:0] offs_b;
    logic [6:0] step_b;
  } stc_dec_t;

  stc_dec_t dec_reg;
  stc_dec_t dec_next;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Offset step is signed so that code 0 sits at the top of the range
  always_comb begin
    dec_next.pump_level = fields.pump_level;
    dec_next.pump_ua = stc_pump_ua(fields.pump_level);
    dec_next.osc_dis = fields.osc_dis;
    dec_next.buf_en = ~fields.osc_dis;
    dec_next.am = fields.am_mode;
    dec_next.ref_sel = fields.am_mode;
    dec_next.gain_a = fields.gain_a;
    dec_next.offs_a = fields.offs_a;
    dec_next.step_a = OFFS_MID - {1'b0, fields.offs_a};
    dec_next.gain_b = fields.gain_b;
    dec_next.offs_b = fields.offs_b;
    dec_next.step_b = OFFS_MID - {1'b0, fields.offs_b};
  end

  // Output register; buffer on and FM mode after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_reg <= '0;
      dec_reg.pump_ua <= PUMP_UA_25;
      dec_reg.buf_en <= 1'b1;
      dec_reg.step_a <= OFFS_MID;
      dec_reg.step_b <= OFFS_MID;
    end else begin
      dec_reg <= dec_next;
    end
  end

  assign pump_current_level = dec_reg.pump_level;
  assign pump_current_ua = dec_reg.pump_ua;
  assign osc_buffer_disable = dec_reg.osc_dis;
  assign ref_buffer_out_en = dec_reg.buf_en;
  assign am_mode = dec_reg.am;
  assign dac_in_ref_sel = dec_reg.ref_sel;
  assign align_dac_a_gain = dec_reg.gain_a;
  assign align_dac_a_offset = dec_reg.offs_a;
  assign align_dac_a_offs_step = dec_reg.step_a;
  assign align_dac_b_gain = dec_reg.gain_b;
  assign align_dac_b_offset = dec_reg.offs_b;
  assign align_dac_b_offs_step = dec_reg.step_b;

endmodule : stc_field_decode

/* File: test/stc_host_model.sv */
// Controller model: frames commands on the enable line and drives the register port
`timescale 1ns/100ps
module stc_host_model (
  input wire logic clk,
  output logic bus_enable,
  output logic [stc_pkg::ADDR_W-1:0] reg_addr,
  output logic [stc_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [stc_pkg::DATA_W-1:0] reg_rdata
);
  import stc_pkg::*;

  // ----------------------------------------------------------------
  // Idle state at time zero
  // ----------------------------------------------------------------
  // Bus lines start idle; nothing is requested before reset releases
  initial begin
    bus_enable = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // ----------------------------------------------------------------
  // Command framing
  // ----------------------------------------------------------------
  // Enable rises to open a command and stays high throughout
  task automatic frame_open();
    @(posedge clk);
    bus_enable <= 1'b1;
  endtask : frame_open

  // Enable falls to end the command, then stays low for at least one edge
  task automatic frame_close();
    @(posedge clk);
    bus_enable <= 1'b0;
    @(posedge clk);
  endtask : frame_close

  // ----------------------------------------------------------------
  // Register port cycles
  // ----------------------------------------------------------------
  // Released lines show the inverse of the last value, so a design that samples stale data is caught
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~addr;
    reg_wdata <= ~data;
  endtask : wr

  // Read data stand only in the cycle after the strobe, sampled mid-cycle
  task automatic rd(input logic [7:0] addr, output logic [31:0] data);
    @(posedge clk);
    reg_addr <= addr;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~addr;
    @(negedge clk);
    data = reg_rdata;
  endtask : rd
endmodule : stc_host_model

/* File: test/synth_tuning_control_bits_test.sv */
// Self-checking bench for the tuning control bit block
`timescale 1ns/100ps
module synth_tuning_control_bits_test;
  import stc_pkg::*;

  logic clk = 1'b0;
  logic rst_n;
  logic bus_enable;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [1:0] pump_current_level;
  logic [11:0] pump_current_ua;
  logic osc_buffer_disable;
  logic ref_buffer_out_en;
  logic am_mode;
  logic dac_in_ref_sel;
  logic [7:0] align_dac_a_gain;
  logic [5:0] align_dac_a_offset;
  logic signed [6:0] align_dac_a_offs_step;
  logic [7:0] align_dac_b_gain;
  logic [5:0] align_dac_b_offset;
  logic signed [6:0] align_dac_b_offs_step;
  logic [1:0] e_pump;
  logic e_osc;
  logic e_am;
  logic [7:0] e_ga;
  logic [5:0] e_oa;
  logic [7:0] e_gb;
  logic [5:0] e_ob;
  logic [31:0] d;
  int err_total;
  int comparisons;

  // ----------------------------------------------------------------
  // Clock, design and controller
  // ----------------------------------------------------------------
  // 40 MHz clock
  always #12.5 clk = ~clk;

  stc_top dut_u (.clk(clk), .rst_n(rst_n), .bus_enable(bus_enable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pump_current_level(pump_current_level), .pump_current_ua(pump_current_ua),
    .osc_buffer_disable(osc_buffer_disable), .ref_buffer_out_en(ref_buffer_out_en), .am_mode(am_mode),
    .dac_in_ref_sel(dac_in_ref_sel), .align_dac_a_gain(align_dac_a_gain),
    .align_dac_a_offset(align_dac_a_offset), .align_dac_a_offs_step(align_dac_a_offs_step),
    .align_dac_b_gain(align_dac_b_gain), .align_dac_b_offset(align_dac_b_offset),
    .align_dac_b_offs_step(align_dac_b_offs_step));

  stc_host_model host_u (.clk(clk), .bus_enable(bus_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ----------------------------------------------------------------
  // Expectations and comparison
  // ----------------------------------------------------------------
  // Pump code to microamperes, worked out independently of the design's table
  function automatic logic [11:0] exp_ua(input logic [1:0] code);
    case (code)
      2'h0: exp_ua = 12'h019;
      2'h1: exp_ua = 12'h064;
      2'h2: exp_ua = 12'h1F4;
      default: exp_ua = 12'h7D0;
    endcase
  endfunction : exp_ua

  // Offset code 0 is most positive, 31 near zero, 63 most negative
  function automatic logic [6:0] exp_step(input logic [5:0] code);
    exp_step = 7'h1F - {1'b0, code};
  endfunction : exp_step

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    comparisons++;
    if (seen !== expd) begin
      err_total++;
      $display("ERROR at %0t: seen %h, expected %h", $time, seen, expd);
    end
  endtask : check

  task automatic check_all();
    check({30'h0, pump_current_level}, {30'h0, e_pump});
    check({20'h0, pump_current_ua}, {20'h0, exp_ua(e_pump)});
    check({31'h0, osc_buffer_disable}, {31'h0, e_osc});
    check({31'h0, ref_buffer_out_en}, {31'h0, ~e_osc});
    check({31'h0, am_mode}, {31'h0, e_am});
    check({31'h0, dac_in_ref_sel}, {31'h0, e_am});
    check({24'h0, align_dac_a_gain}, {24'h0, e_ga});
    check({24'h0, align_dac_b_gain}, {24'h0, e_gb});
    check({26'h0, align_dac_a_offset}, {26'h0, e_oa});
    check({26'h0, align_dac_b_offset}, {26'h0, e_ob});
    check({25'h0, align_dac_a_offs_step}, {25'h0, exp_step(e_oa)});
    check({25'h0, align_dac_b_offs_step}, {25'h0, exp_step(e_ob)});
  endtask : check_all

  // ----------------------------------------------------------------
  // One framed command carrying a full setting
  // ----------------------------------------------------------------
  // Junk in unimplemented bits must be dropped; outputs may only move after enable falls
  task automatic apply(input logic [1:0] p, input logic o, input logic a, input logic [7:0] ga,
                       input logic [5:0] oa, input logic [7:0] gb, input logic [5:0] ob);
    logic [31:0] r;
    host_u.frame_open();
    host_u.wr(ADDR_WORD0, 32'hFFFFFFFF);
    host_u.rd(ADDR_WORD0, r);
    check(r, 32'h00003FFF);
    host_u.wr(ADDR_WORD0, {18'h3FFFF, ob, gb});
    host_u.wr(ADDR_WORD1, {14'h3FFF, oa, ga, 1'b1, a, 2'h3});
    host_u.wr(ADDR_WORD2, {24'hFFFFFF, p, o, 5'h1F});
    host_u.wr(ADDR_STATUS, 32'hFFFFFFFF);
    host_u.rd(ADDR_WORD1, r);
    check(r, {14'h0, oa, ga, 1'b0, a, 2'h0});
    host_u.rd(ADDR_WORD2, r);
    check(r, {24'h0, p, o, 5'h0});
    host_u.rd(ADDR_STATUS, r);
    check(r, {27'h0, e_osc, e_pump, e_am, 1'b1});
    check_all();
    host_u.frame_close();
    repeat (3) @(posedge clk);
    #1;
    e_pump = p;
    e_osc = o;
    e_am = a;
    e_ga = ga;
    e_oa = oa;
    e_gb = gb;
    e_ob = ob;
    check_all();
    host_u.rd(ADDR_STATUS, r);
    check(r, {27'h0, o, p, a, 1'b0});
  endtask : apply

  // ----------------------------------------------------------------
  // Verdict and watchdog
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // The whole sequence needs well under 1000 cycles; 4000 cycles means a hang
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Corner codes first (extremes and the offset midpoint, every pump code), then random settings
  initial begin
    rst_n = 1'b0;
    err_total = 0;
    comparisons = 0;
    {e_pump, e_osc, e_am, e_ga, e_oa, e_gb, e_ob} = '0;
    void'($urandom(32'h270352fa));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check_all();
    host_u.rd(8'h10, d);
    check(d, 32'h00000000);
    for (int i = 0; i < 4; i++) begin
      apply(2'(i), i[0], i[1], {8{i[0]}}, (i == 2) ? 6'h1F : {6{i[1]}}, {8{~i[0]}}, {6{~i[1]}});
    end
    // Corner: a write sampled in the commit cycle must stay staged with pending still set
    host_u.frame_open();
    fork
      host_u.frame_close();
      begin
        @(posedge clk);
        host_u.wr(ADDR_WORD0, 32'h00003FFF);
      end
    join
    repeat (2) @(posedge clk);
    #1;
    check_all();
    host_u.rd(ADDR_WORD0, d);
    check(d, 32'h00003FFF);
    host_u.rd(ADDR_STATUS, d);
    check(d, {27'h0, e_osc, e_pump, e_am, 1'b1});
    repeat (6) begin
      apply(2'($urandom), 1'($urandom), 1'($urandom), 8'($urandom), 6'($urandom), 8'($urandom),
            6'($urandom));
    end
    report_and_stop();
  end
endmodule : synth_tuning_control_bits_test
